// File: hdl/tsm_regs.sv
// Purpose: Mask, live status, health and mode registers with request output
// Assumes: Comparator and event inputs are synchronous to CLK_I
// Notes: Latched flag register sits outside; its bits arrive on FLAGS_I
`timescale 1ns/1ps
module tsm_regs (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic MOSI_I,
	output logic MISO_O,
	output logic MISO_OE_O,
	input wire logic [7:0] FLAGS_I,
	output logic FLAG_RD_O,
	output logic IRQ_O,
	input wire logic LINE_HIGH_I,
	input wire logic DRV_FAULT_I,
	input wire logic LOW_VOLT_BELOW_LO_I,
	input wire logic LOW_VOLT_ABOVE_HI_I,
	input wire logic FIELD_BELOW_FALL_I,
	input wire logic FIELD_ABOVE_RISE_I,
	input wire logic TEMP_ABOVE_HI_I,
	input wire logic TEMP_BELOW_LO_I,
	input wire logic CONV_FAULT_I,
	input wire logic CONV_STEADY_I,
	input wire logic CORRUPT_EVT_I,
	output logic SOFT_RST_O,
	output logic [1:0] CONV_MODE_O,
	output logic CONV_SPREAD_O,
	output logic CONV_DISABLE_O,
	output logic DRV_DISABLE_O,
	output logic RX_HIZ_O,
	output logic REG33_FORCE_ON_O,
	output logic CLK_OUT_EN_O
);
	logic [4:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] bus_rdata;
	logic [7:0] mask_q;
	logic [7:0] mask_d;
	logic [3:0] mode_q;
	logic [3:0] mode_d;
	logic corrupt_q;
	logic corrupt_d;
	logic ready_q;
	logic ready_d;
	logic line_inv_q;
	logic drv_fault_q;
	logic conv_fault_q;
	logic soft_rst_q;
	logic low_volt;
	logic field_uv;
	logic therm_warn;
	logic [7:0] live_flags;
	logic [7:0] health_flags;
	logic [7:0] flag_gate;
	logic wr_mask;
	logic wr_mode;
	logic soft_rst_req;
	tsm_pkg::tsm_conv_mode_t conv_mode;

	// Serial register port
	tsm_spi u_spi (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.sclk_i(SCLK_I),
		.cs_n_i(CS_N_I),
		.mosi_i(MOSI_I),
		.miso_o(MISO_O),
		.miso_oe_o(MISO_OE_O),
		.addr_o(bus_addr),
		.wdata_o(bus_wdata),
		.wr_o(bus_wr),
		.rd_o(bus_rd),
		.rdata_i(bus_rdata)
	);

	// Low-voltage monitor with hysteresis
	tsm_hyst #(.RESET_VAL(1'b0)) u_low_volt ( // RL9
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.set_i(LOW_VOLT_BELOW_LO_I),
		.clr_i(LOW_VOLT_ABOVE_HI_I),
		.state_o(low_volt)
	);

	// Field supply undervoltage with hysteresis
	tsm_hyst #(.RESET_VAL(1'b0)) u_field_uv ( // RL10
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.set_i(FIELD_BELOW_FALL_I),
		.clr_i(FIELD_ABOVE_RISE_I),
		.state_o(field_uv)
	);

	// Die temperature warning with hysteresis
	tsm_hyst #(.RESET_VAL(1'b0)) u_therm_warn ( // RL11
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.set_i(TEMP_ABOVE_HI_I),
		.clr_i(TEMP_BELOW_LO_I),
		.state_o(therm_warn)
	);

	// Write decode
	assign wr_mask = bus_wr && bus_addr == tsm_pkg::ADDR_MASK;
	assign wr_mode = bus_wr && bus_addr == tsm_pkg::ADDR_MODE;
	assign soft_rst_req = wr_mode && bus_wdata[tsm_pkg::BIT_SOFT_RST]; // RL16

	// Mask register next value; only documented bits take writes
	assign mask_d = soft_rst_q ? tsm_pkg::MASK_RESET : // RL16
		(wr_mask ? (bus_wdata & tsm_pkg::MASK_WR_BITS) : mask_q); // RL3 RL4 RL21

	// Mode register next value; bit 7 is never stored
	assign mode_d = soft_rst_q ? tsm_pkg::MODE_RESET : // RL16
		(wr_mode ? (bus_wdata[3:0] & tsm_pkg::MODE_WR_BITS) : mode_q); // RL18

	// Corruption stays until a soft reset restores the registers
	assign corrupt_d = CORRUPT_EVT_I ? 1'b1 : (soft_rst_q ? 1'b0 : corrupt_q);

	// Converter health follows the live converter state
	assign ready_d = CONV_STEADY_I & ~CONV_FAULT_I; // RL15

	// Live status register image
	assign live_flags = {line_inv_q, 2'b00, drv_fault_q, low_volt, field_uv, // RL6 RL9 RL10
		1'b0, therm_warn}; // RL11 RL21

	// Health register image
	assign health_flags = {corrupt_q, 5'b00000, conv_fault_q, ready_q}; // RL14 RL15 RL21

	// Read mux; unmapped addresses read zero
	assign bus_rdata = (bus_addr == tsm_pkg::ADDR_FLAGS) ? FLAGS_I :
		(bus_addr == tsm_pkg::ADDR_MASK) ? mask_q :
		(bus_addr == tsm_pkg::ADDR_LIVE) ? live_flags :
		(bus_addr == tsm_pkg::ADDR_HEALTH) ? health_flags :
		(bus_addr == tsm_pkg::ADDR_MODE) ? {4'h0, mode_q} :
		8'h00; // RL21

	// Reads of the flag register are forwarded so the flags clear there
	assign FLAG_RD_O = bus_rd && bus_addr == tsm_pkg::ADDR_FLAGS; // RL19

	// Mask gates the request only; flags themselves pass untouched
	assign flag_gate = FLAGS_I & ~mask_q; // RL1 RL2
	assign IRQ_O = FLAGS_I[tsm_pkg::BIT_UNREADY] | // RL20
		flag_gate[tsm_pkg::BIT_WAKE] | flag_gate[tsm_pkg::BIT_CONV_DONE] |
		flag_gate[tsm_pkg::BIT_DRV_FAULT] | flag_gate[tsm_pkg::BIT_LOW_VOLT] |
		flag_gate[tsm_pkg::BIT_FIELD_UV] | flag_gate[tsm_pkg::BIT_THERM_WARN]; // RL19

	// Converter mode priority: discontinuous, then pulse-frequency, then PWM
	assign conv_mode = mode_q[tsm_pkg::BIT_DCM_SEL] ? tsm_pkg::TSM_CONV_DCM : // RL17
		(mode_q[tsm_pkg::BIT_PFM_SEL] ? tsm_pkg::TSM_CONV_PFM : tsm_pkg::TSM_CONV_PWM);
	assign CONV_MODE_O = conv_mode;
	assign CONV_SPREAD_O = mode_q[tsm_pkg::BIT_SPREAD]; // RL18

	// Corruption overrides the converter disable and the line path
	assign CONV_DISABLE_O = mode_q[tsm_pkg::BIT_CONV_DIS] & ~corrupt_q; // RL13 RL18
	assign DRV_DISABLE_O = corrupt_q; // RL13
	assign RX_HIZ_O = corrupt_q; // RL13
	assign REG33_FORCE_ON_O = corrupt_q; // RL13
	assign CLK_OUT_EN_O = corrupt_q; // RL13
	assign SOFT_RST_O = soft_rst_q;

	// Control registers
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			mask_q <= tsm_pkg::MASK_RESET;
			mode_q <= tsm_pkg::MODE_RESET;
			soft_rst_q <= 1'b0;
			corrupt_q <= 1'b0;
		end else begin
			mask_q <= mask_d;
			mode_q <= mode_d;
			soft_rst_q <= soft_rst_req; // RL16
			corrupt_q <= corrupt_d;
		end
	end

	// Live status samplers; no read ever touches them
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			line_inv_q <= 1'b0;
			drv_fault_q <= 1'b0;
			conv_fault_q <= 1'b0;
			ready_q <= tsm_pkg::CONV_READY_RESET; // RL15
		end else begin
			line_inv_q <= ~LINE_HIGH_I; // RL7
			drv_fault_q <= DRV_FAULT_I; // RL8
			conv_fault_q <= CONV_FAULT_I; // RL14
			ready_q <= ready_d;
		end
	end

	// Checks
	default clocking chk_clk @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	// Masked flags never raise the request
	chk_mask_blocks_irq: assert property ( // RL1
		(FLAGS_I[7] == 1'b0 && (FLAGS_I & ~mask_q) == 8'h00) |-> !IRQ_O)
		else $error("request raised by masked flag");

	// Unmaskable not-ready flag
	chk_unready_irq: assert property ( // RL20
		FLAGS_I[tsm_pkg::BIT_UNREADY] |-> IRQ_O)
		else $error("not-ready flag did not raise request");

	// Unmasked flag raises request
	chk_flag_irq: assert property ( // RL19
		((FLAGS_I & ~mask_q & tsm_pkg::MASK_WR_BITS) != 8'h00) |-> IRQ_O)
		else $error("unmasked flag did not raise request");

	// Mask write lands in the next cycle, unused bits zero
	chk_mask_write: assert property ( // RL3
		(wr_mask && !soft_rst_q) |=> mask_q == ($past(bus_wdata) & 8'h7D))
		else $error("mask write not stored");

	// Unused mask bits read zero
	chk_mask_unused: assert property ( // RL4
		mask_q[7] == 1'b0 && mask_q[1] == 1'b0)
		else $error("unused mask bit set");

	// Line level inverted one cycle later
	chk_line_inv: assert property ( // RL7
		##1 live_flags[tsm_pkg::BIT_LINE_INV] == !$past(LINE_HIGH_I))
		else $error("line level bit wrong");

	// Driver fault follows input one cycle later
	chk_drv_fault: assert property ( // RL8
		##1 live_flags[tsm_pkg::BIT_DRV_FAULT] == $past(DRV_FAULT_I))
		else $error("driver fault bit wrong");

	// Low-voltage bit holds between thresholds
	chk_low_volt_hold: assert property ( // RL9
		(!LOW_VOLT_BELOW_LO_I && !LOW_VOLT_ABOVE_HI_I) |=> $stable(low_volt))
		else $error("low voltage bit moved inside hysteresis");

	// Field undervoltage sets below the falling level
	chk_field_uv: assert property ( // RL10
		FIELD_BELOW_FALL_I |=> field_uv)
		else $error("field undervoltage not set");

	// Thermal warning clears below lower threshold
	chk_therm_clear: assert property ( // RL11
		(TEMP_BELOW_LO_I && !TEMP_ABOVE_HI_I) |=> !therm_warn)
		else $error("thermal warning not cleared");

	// Status reads leave live bits alone
	chk_read_no_clear: assert property ( // RL6
		(bus_rd && bus_addr == tsm_pkg::ADDR_LIVE && !LOW_VOLT_ABOVE_HI_I && low_volt)
		|=> low_volt)
		else $error("status read cleared a bit");

	// Corruption forces the safe outputs
	chk_corrupt_safe: assert property ( // RL13
		corrupt_q |-> (DRV_DISABLE_O && RX_HIZ_O && REG33_FORCE_ON_O && CLK_OUT_EN_O
			&& !CONV_DISABLE_O))
		else $error("corruption did not force safe state");

	// Converter fault reported one cycle later
	chk_conv_fault: assert property ( // RL14
		CONV_FAULT_I |=> health_flags[tsm_pkg::BIT_CONV_FAULT] && !ready_q)
		else $error("converter fault not reported");

	// Ready only in fault-free steady state
	chk_conv_ready: assert property ( // RL15
		(CONV_STEADY_I && !CONV_FAULT_I) |=> ready_q)
		else $error("converter ready not reported");

	// Soft reset restores defaults two cycles after the write
	chk_soft_reset: assert property ( // RL16
		soft_rst_req |=> soft_rst_q ##1 (mask_q == 8'h00 && mode_q == 4'h0 && !soft_rst_q))
		else $error("soft reset did not restore defaults");

	// Mode priority
	chk_mode_prio: assert property ( // RL17
		mode_q[3] |-> CONV_MODE_O == 2'h2)
		else $error("discontinuous mode not chosen");

	// Spread spectrum follows its bit
	chk_spread: assert property ( // RL18
		CONV_SPREAD_O == mode_q[tsm_pkg::BIT_SPREAD])
		else $error("spread enable wrong");

	// Unmapped reads return zero
	chk_unmapped_zero: assert property ( // RL21
		(bus_addr > tsm_pkg::ADDR_MODE) |-> bus_rdata == 8'h00)
		else $error("unmapped address read nonzero");

	// Flag reads forwarded as a single pulse
	chk_flag_rd_pulse: assert property ( // RL19
		FLAG_RD_O |=> !FLAG_RD_O)
		else $error("flag read pulse too long");

	// Mask never alters the flags on the request path
	chk_flags_pass: assert property ( // RL2
		(FLAGS_I[tsm_pkg::BIT_WAKE] && !mask_q[tsm_pkg::BIT_WAKE]) |-> IRQ_O)
		else $error("flag lost on request path");

	// Low-voltage bit sets below the lower level
	chk_low_volt_set: assert property ( // RL9
		LOW_VOLT_BELOW_LO_I |=> low_volt)
		else $error("low voltage bit not set");

	// Low-voltage bit clears above the upper level
	chk_low_volt_clear: assert property ( // RL9
		(LOW_VOLT_ABOVE_HI_I && !LOW_VOLT_BELOW_LO_I) |=> !low_volt)
		else $error("low voltage bit not cleared");

	// Field undervoltage clears above the rising level
	chk_field_uv_clear: assert property ( // RL10
		(FIELD_ABOVE_RISE_I && !FIELD_BELOW_FALL_I) |=> !field_uv)
		else $error("field undervoltage not cleared");

	// Thermal warning sets above the upper level
	chk_therm_set: assert property ( // RL11
		TEMP_ABOVE_HI_I |=> therm_warn)
		else $error("thermal warning not set");

	// Pulse-frequency mode when only its bit is set
	chk_pulse_freq_mode: assert property ( // RL17
		(!mode_q[tsm_pkg::BIT_DCM_SEL] && mode_q[tsm_pkg::BIT_PFM_SEL]) |-> CONV_MODE_O == 2'h1)
		else $error("pulse frequency mode not chosen");

	// Mode write lands in the next cycle
	chk_mode_write: assert property ( // RL18
		(wr_mode && !soft_rst_q) |=> mode_q == $past(bus_wdata[3:0]))
		else $error("mode write not stored");

	// Converter disable follows its bit while not corrupted
	chk_conv_disable: assert property ( // RL18
		!corrupt_q |-> CONV_DISABLE_O == mode_q[tsm_pkg::BIT_CONV_DIS])
		else $error("converter disable wrong");

	// Soft reset clears the corruption bit
	chk_corrupt_clear: assert property ( // RL16
		(soft_rst_q && !CORRUPT_EVT_I) |=> !corrupt_q)
		else $error("corruption bit survived soft reset");

	// Main scenarios
	cov_mask_write: cover property (wr_mask ##1 mask_q != 8'h00);
	cov_soft_reset: cover property (soft_rst_req ##2 mode_q == 4'h0);
	cov_corrupt: cover property (CORRUPT_EVT_I ##1 corrupt_q);
	cov_masked_flag: cover property (FLAGS_I[4] && mask_q[4] && !IRQ_O);
	cov_unready_irq: cover property (FLAGS_I[tsm_pkg::BIT_UNREADY] && IRQ_O);
endmodule : tsm_regs

// File: common/tsm_pkg.sv
// Purpose: Constants for the transceiver status, mask and mode register bank
// Assumes: 8-bit registers, 5-bit register address carried in the serial frame
// Notes: Offsets, field positions and reset values live here; some checks and the bench also spell them out as literals
// What this block does
// [RL1] A set latched flag whose mask bit is one never drives the request output.
// [RL2] Flags still latch on events; the mask only gates the request output.
// [RL3] Mask bits 6, 5, 4 gate wake, conversion-done, driver fault; reset zero, read/write.
// [RL4] Mask bits 3, 2, 0 gate low-voltage, field undervoltage, thermal warning; bit 1 unused.
// [RL5] Host sets the thermal warning mask when manual conversion (10 or 11) is chosen.
// [RL6] Both status registers are read-only, follow live state, and reads clear nothing.
// [RL7] Status bit 7 is the line level inverted: one when the line is low.
// [RL8] Status bit 4 is one while the line driver has an overcurrent or thermal fault.
// [RL9] Status bit 3 sets below the lower comparator level, clears above the upper one.
// [RL10] Status bit 2 sets below the falling field threshold, clears above the rising one.
// [RL11] Status bit 0 sets above the upper temperature, clears below the lower one.
// [RL12] Host ignores the thermal warning status bit while manual conversion is chosen.
// [RL13] Corruption forces driver off, receive output high-Z, regulators on, clock output on.
// [RL14] Health bit 1 is one while the buck converter reports any fault.
// [RL15] Health bit 0 resets to one and is one only in steady, fault-free operation.
// [RL16] Writing one to mode bit 7 restores all register defaults; bit self-clears.
// [RL17] Converter mode: bit 3 picks discontinuous, else bit 2 pulse-frequency, else PWM.
// [RL18] Mode bit 1 enables spread spectrum, bit 0 disables converter; both reset zero.
// [RL19] Request output follows any unmasked set flag and drops once flags are cleared.
// [RL20] The not-ready flag has no mask and can always raise the request output.
// [RL21] Unused register bits read as zero and ignore writes.
package tsm_pkg;
	// Register addresses
	localparam logic [4:0] ADDR_FLAGS = 5'h00;
	localparam logic [4:0] ADDR_MASK = 5'h01;
	localparam logic [4:0] ADDR_LIVE = 5'h02;
	localparam logic [4:0] ADDR_HEALTH = 5'h03;
	localparam logic [4:0] ADDR_MODE = 5'h04;
	// Flag and mask field positions
	localparam int BIT_UNREADY = 7;
	localparam int BIT_WAKE = 6;
	localparam int BIT_CONV_DONE = 5;
	localparam int BIT_DRV_FAULT = 4;
	localparam int BIT_LOW_VOLT = 3;
	localparam int BIT_FIELD_UV = 2;
	localparam int BIT_THERM_WARN = 0;
	// Live status field positions
	localparam int BIT_LINE_INV = 7;
	// Health field positions
	localparam int BIT_CORRUPT = 7;
	localparam int BIT_CONV_FAULT = 1;
	localparam int BIT_CONV_READY = 0;
	// Mode field positions
	localparam int BIT_SOFT_RST = 7;
	localparam int BIT_DCM_SEL = 3;
	localparam int BIT_PFM_SEL = 2;
	localparam int BIT_SPREAD = 1;
	localparam int BIT_CONV_DIS = 0;
	// Writable bit masks and reset values
	localparam logic [7:0] MASK_WR_BITS = 8'h7D;
	localparam logic [3:0] MODE_WR_BITS = 4'hF;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic CONV_READY_RESET = 1'b1;
	// Serial frame layout
	localparam int FRAME_BITS = 16;
	localparam int HDR_WRITE_BIT = 7;
	// Converter operating mode
	typedef enum logic [1:0] {
		TSM_CONV_PWM,
		TSM_CONV_PFM,
		TSM_CONV_DCM
	} tsm_conv_mode_t;
endpackage : tsm_pkg

// File: hdl/tsm_hyst.sv
// Purpose: Hysteresis latch driven by a pair of comparator outputs
// Assumes: Comparator levels are synchronous to the clock
// Notes: Set wins when both comparators report at once
`timescale 1ns/1ps
module tsm_hyst #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic state_o
);
	logic state_q;
	logic state_d;

	// Hold between the two thresholds
	assign state_d = set_i ? 1'b1 : (clr_i ? 1'b0 : state_q);
	assign state_o = state_q;

	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= RESET_VAL;
		end else begin
			state_q <= state_d;
		end
	end
endmodule : tsm_hyst

// File: hdl/tsm_spi.sv
// Purpose: Serial register port, mode 0, 16-bit frames
// Assumes: Serial pins are synchronous and much slower than the clock
// Notes: Header byte: bit 7 write, bits 4:0 address; then one data byte
`timescale 1ns/1ps
module tsm_spi (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic [4:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	logic sclk_q;
	logic [4:0] cnt_q;
	logic [7:0] in_q;
	logic [7:0] hdr_q;
	logic [7:0] out_q;
	logic hdr_done_q;
	logic wr_q;
	logic [7:0] wdata_q;
	logic rise;
	logic fall;
	logic [7:0] in_next;
	// Bit counter end points of the header and of the whole frame
	localparam logic [4:0] HDR_LAST = 5'(tsm_pkg::FRAME_BITS / 2 - 1);
	localparam logic [4:0] FRAME_LAST = 5'(tsm_pkg::FRAME_BITS - 1);

	// Edge detect on the serial clock
	assign rise = ~cs_n_i & sclk_i & ~sclk_q;
	assign fall = ~cs_n_i & ~sclk_i & sclk_q;
	assign in_next = {in_q[6:0], mosi_i};
	assign addr_o = hdr_q[4:0];
	assign wdata_o = wdata_q;
	assign wr_o = wr_q;
	assign rd_o = hdr_done_q & ~hdr_q[tsm_pkg::HDR_WRITE_BIT];
	assign miso_o = out_q[7];
	assign miso_oe_o = ~cs_n_i;

	// Frame shifter
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
			cnt_q <= 5'h00;
			in_q <= 8'h00;
			hdr_q <= 8'h00;
			out_q <= 8'h00;
			hdr_done_q <= 1'b0;
			wr_q <= 1'b0;
			wdata_q <= 8'h00;
		end else begin
			sclk_q <= sclk_i;
			hdr_done_q <= rise && cnt_q == HDR_LAST;
			wr_q <= rise && cnt_q == FRAME_LAST && hdr_q[tsm_pkg::HDR_WRITE_BIT];
			if (cs_n_i) begin
				cnt_q <= 5'h00;
			end else if (rise) begin
				cnt_q <= cnt_q + 5'h01;
				in_q <= in_next;
				if (cnt_q == HDR_LAST) begin
					hdr_q <= in_next;
				end
				if (cnt_q == FRAME_LAST) begin
					wdata_q <= in_next;
				end
			end
			if (hdr_done_q) begin
				out_q <= rdata_i;
			end else if (fall && cnt_q > HDR_LAST + 5'h01) begin
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end
endmodule : tsm_spi

// File: verification/tsm_host.sv
// Purpose: Host controller model driving the serial register port
// Assumes: Mode 0 framing, 16 bits, every serial clock level held four clock cycles, each data bit eight
// Notes: Data line shows the inverse of its last bit while the frame is idle
`timescale 1ns/1ps
module tsm_host (
	input wire logic clk_i,
	input wire logic miso_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o
);
	// Idle levels before the first frame
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_data_o = 8'h00;
	end

	// One whole frame; called just after a falling clock edge
	task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat);
		logic [15:0] fr;
		logic [7:0] rd;
		fr = {hdr, dat};
		rd = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = fr[i];
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b1;
			if (i < 8) begin
				rd = {rd[6:0], miso_i};
			end
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		if (!hdr[7]) begin
			rd_data_o = rd;
			rd_valid_o = 1'b1;
		end
		@(negedge clk_i);
		rd_valid_o = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask : xfer
endmodule : tsm_host

// File: verification/testbench.sv
// Purpose: Self-checking bench for the status, mask and mode register bank
// Assumes: Inputs change at falling clock edges; read results queue up in order
// Notes: Flag register image comes from random and fixed values, all with the unused bit low
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] flags = 8'h00;
	logic line_high = 1'b1, drv_fault = 1'b0, lv_lo = 1'b0, lv_hi = 1'b0;
	logic fd_fall = 1'b0, fd_rise = 1'b0, t_hi = 1'b0, t_lo = 1'b0;
	logic conv_fault = 1'b0, conv_steady = 1'b1, corrupt = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, flag_rd, irq, soft_rst;
	logic spread, conv_dis, drv_dis, rx_hiz, reg33_on, clk_out_en, rd_valid;
	logic [1:0] conv_mode;
	logic [7:0] rd_data, m, f;
	logic [7:0] exp_q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 32'h014b;
	int soft_cnt = 0;
	int frd_cnt = 0;
	int s;

	always #20 clk = ~clk;

	tsm_regs dut_u (.CLK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi),
		.MISO_O(miso), .MISO_OE_O(miso_oe), .FLAGS_I(flags), .FLAG_RD_O(flag_rd), .IRQ_O(irq),
		.LINE_HIGH_I(line_high), .DRV_FAULT_I(drv_fault), .LOW_VOLT_BELOW_LO_I(lv_lo),
		.LOW_VOLT_ABOVE_HI_I(lv_hi), .FIELD_BELOW_FALL_I(fd_fall), .FIELD_ABOVE_RISE_I(fd_rise),
		.TEMP_ABOVE_HI_I(t_hi), .TEMP_BELOW_LO_I(t_lo), .CONV_FAULT_I(conv_fault),
		.CONV_STEADY_I(conv_steady), .CORRUPT_EVT_I(corrupt), .SOFT_RST_O(soft_rst),
		.CONV_MODE_O(conv_mode), .CONV_SPREAD_O(spread), .CONV_DISABLE_O(conv_dis),
		.DRV_DISABLE_O(drv_dis), .RX_HIZ_O(rx_hiz), .REG33_FORCE_ON_O(reg33_on),
		.CLK_OUT_EN_O(clk_out_en));

	tsm_host host_u (.clk_i(clk), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.rd_valid_o(rd_valid), .rd_data_o(rd_data));

	// Compare one value and count it
	task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host_u.xfer({3'b100, a}, d);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.xfer({3'b000, a}, 8'h00);
	endtask : rd

	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	// Read results against the oldest note; pulse counters
	always @(posedge clk) begin
		cmp_val({7'h0, miso_oe}, {7'h0, ~cs_n});
		if (rd_valid === 1'b1 && exp_q.size() > 0) begin
			cmp_val(rd_data, exp_q.pop_front());
		end
		if (soft_rst === 1'b1) begin
			soft_cnt++;
		end
		if (flag_rd === 1'b1) begin
			frd_cnt++;
		end
	end

	// Hang guard
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		test_done();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		rd(tsm_pkg::ADDR_MASK, 8'h00);
		rd(tsm_pkg::ADDR_LIVE, 8'h00);
		rd(tsm_pkg::ADDR_HEALTH, 8'h01);
		rd(tsm_pkg::ADDR_MODE, 8'h00);
		rd(5'h1F, 8'h00);
		wr(tsm_pkg::ADDR_MASK, 8'hFF);
		rd(tsm_pkg::ADDR_MASK, 8'h7D);
		wr(tsm_pkg::ADDR_LIVE, 8'hFF);
		rd(tsm_pkg::ADDR_LIVE, 8'h00);
		// Every converter mode setting
		for (int i = 0; i < 16; i++) begin
			wr(tsm_pkg::ADDR_MODE, 8'(i));
			rd(tsm_pkg::ADDR_MODE, 8'(i));
			cmp_val({6'h0, conv_mode}, i[3] ? 8'h02 : {7'h0, i[2]});
			cmp_val({6'h0, spread, conv_dis}, {6'h0, i[1:0]});
		end
		// Request output: random masks and flags, then fixed corners
		for (int k = 0; k < 11; k++) begin
			m = 8'($random(seed)) & 8'h7D;
			f = 8'($random(seed)) & 8'hFD;
			if (k == 8) {m, f} = {8'h7D, 8'h7D};
			if (k == 9) {m, f} = {8'h7D, 8'h80};
			// Manual conversion assumed: thermal warning masked, its status ignored
			if (k == 10) {m, f} = {8'h01, 8'h01};
			wr(tsm_pkg::ADDR_MASK, m);
			flags = f;
			#1 cmp_val({7'h0, irq}, {7'h0, f[7] | |(f & ~m)});
			@(negedge clk);
		end
		// Flag image read back through the port; the read is forwarded once
		flags = 8'h45;
		s = frd_cnt;
		rd(tsm_pkg::ADDR_FLAGS, 8'h45);
		cmp_val(8'(frd_cnt - s), 8'h01);
		flags = 8'h00;
		#1 cmp_val({7'h0, irq}, 8'h00);
		@(negedge clk);
		// Live conditions set, then held by hysteresis
		line_high = 1'b0;
		drv_fault = 1'b1;
		{lv_lo, fd_fall, t_hi} = 3'b111;
		@(negedge clk) {lv_lo, fd_fall, t_hi} = 3'b000;
		rd(tsm_pkg::ADDR_LIVE, 8'h9D);
		rd(tsm_pkg::ADDR_LIVE, 8'h9D);
		line_high = 1'b1;
		drv_fault = 1'b0;
		{lv_hi, fd_rise, t_lo} = 3'b111;
		@(negedge clk) {lv_hi, fd_rise, t_lo} = 3'b000;
		rd(tsm_pkg::ADDR_LIVE, 8'h00);
		// Converter health
		conv_fault = 1'b1;
		conv_steady = 1'b0;
		rd(tsm_pkg::ADDR_HEALTH, 8'h02);
		conv_fault = 1'b0;
		rd(tsm_pkg::ADDR_HEALTH, 8'h00);
		conv_steady = 1'b1;
		rd(tsm_pkg::ADDR_HEALTH, 8'h01);
		// Corruption forcing, then soft reset
		wr(tsm_pkg::ADDR_MODE, 8'h01);
		corrupt = 1'b1;
		@(negedge clk) corrupt = 1'b0;
		@(negedge clk);
		cmp_val({3'h0, drv_dis, rx_hiz, reg33_on, clk_out_en, conv_dis}, 8'h1E);
		rd(tsm_pkg::ADDR_HEALTH, 8'h81);
		wr(tsm_pkg::ADDR_MASK, 8'h7D);
		s = soft_cnt;
		wr(tsm_pkg::ADDR_MODE, 8'h80);
		cmp_val(8'(soft_cnt - s), 8'h01);
		rd(tsm_pkg::ADDR_MASK, 8'h00);
		rd(tsm_pkg::ADDR_MODE, 8'h00);
		rd(tsm_pkg::ADDR_HEALTH, 8'h01);
		cmp_val({3'h0, drv_dis, rx_hiz, reg33_on, clk_out_en, conv_dis}, 8'h00);
		test_done();
	end
endmodule : testbench
